//--- logic/scsc_pkg.sv
// Constants, register map and carrier types for the stepper current and standby control block
package scsc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned TICK_MS = 10;
	localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_BOOST = 8'hc8;
	localparam logic [7:0] IDX_FREEWHEEL = 8'hcc;
	localparam logic [7:0] IDX_LOAD = 8'hce;
	localparam logic [7:0] IDX_STALL_FLAG = 8'hcf;
	localparam logic [7:0] IDX_FAULT = 8'hd0;
	localparam logic [7:0] IDX_PD_DELAY = 8'hd6;
	localparam logic [7:0] IDX_MODE = 8'hfe;
	localparam logic [7:0] IDX_RUN = 8'h06;
	localparam logic [7:0] IDX_HOLD = 8'h07;
	localparam logic [7:0] IDX_STEP_IDLE = 8'hf0;
	localparam logic [7:0] IDX_IRQ_STAT = 8'hf1;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hf2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_BOOST = 8'h00;
	localparam logic [15:0] RST_FREEWHEEL = 16'h0000;
	localparam logic [15:0] RST_PD_DELAY = 16'h00c8;
	localparam logic [7:0] RST_RUN = 8'h80;
	localparam logic [7:0] RST_HOLD = 8'h20;
	localparam logic [15:0] RST_STEP_IDLE = 16'h0032;
	localparam logic [3:0] RST_IRQ_MASK = 4'h0;

	// ----------------------------------------------------------------
	// Interrupt status bit positions
	// ----------------------------------------------------------------
	localparam int IRQ_W = 4;
	localparam int IRQ_STALL = 0;
	localparam int IRQ_STANDBY = 1;
	localparam int IRQ_FREEWHEEL = 2;
	localparam int IRQ_FAULT = 3;

	typedef enum logic [2:0] {
		MODE_CMD = 3'h0,
		MODE_ENA = 3'h1,
		MODE_AUTO = 3'h2,
		MODE_RUN = 3'h3,
		MODE_AUTO_EN = 3'h4,
		MODE_RUN_EN = 3'h5
	} scsc_mode_t;

	typedef struct packed {
		logic velocity_zero;
		logic ramping;
		logic stall_detect;
		logic motion_start;
	} scsc_motion_t;

	typedef struct packed {
		logic power_en;
		logic stage_en;
		logic [7:0] current;
	} scsc_drv_t;

endpackage

//--- logic/scsc_top.sv
// Motor current selection, standstill standby, freewheel cut-off and stall flag with APB registers
//
// Contract
// - Ramping uses boost current, zero means run
// - Freewheel delay cuts power; zero means never
// - Read-only stall load value, 0 to 1023
// - Stall stop sets the stall flag
// - Flag clears on read or new motion
// - Standstill delay switches to standby current
// - Mode 0 ignores step/direction pins
// - Mode 1 enable pin picks hold/run
// - Mode 2 auto run/hold, enable ignored
// - Mode 3 permanent run current, enable ignored
// - Mode 4 auto switching, enable gates stages
// - Mode 5 run current, enable gates stages
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
module scsc_top import scsc_pkg::*; #(
	parameter int unsigned TICK_LEN = TICK_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire scsc_motion_t motion,
	input wire logic [9:0] load_value,
	input wire logic [7:0] driver_faults,
	input wire logic step_pin,
	input wire logic enable_pin,
	output scsc_drv_t drv,
	output logic stall_stop,
	output logic irq
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] boost_q, run_q, hold_q;
	logic [15:0] fw_delay_q, pd_delay_q, step_idle_q;
	scsc_mode_t mode_q;
	logic [9:0] load_q;
	logic [7:0] fault_q;
	logic stall_flag_q;
	logic [IRQ_W-1:0] irq_stat_q, irq_mask_q;
	logic [31:0] prdata_q;
	logic rd_valid_q;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire [7:0] idx = paddr[9:2];
	wire addr_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
	wire hit_boost = addr_ok && (idx == IDX_BOOST);
	wire hit_fw = addr_ok && (idx == IDX_FREEWHEEL);
	wire hit_load = addr_ok && (idx == IDX_LOAD);
	wire hit_flag = addr_ok && (idx == IDX_STALL_FLAG);
	wire hit_fault = addr_ok && (idx == IDX_FAULT);
	wire hit_pd = addr_ok && (idx == IDX_PD_DELAY);
	wire hit_mode = addr_ok && (idx == IDX_MODE);
	wire hit_run = addr_ok && (idx == IDX_RUN);
	wire hit_hold = addr_ok && (idx == IDX_HOLD);
	wire hit_idle = addr_ok && (idx == IDX_STEP_IDLE);
	wire hit_istat = addr_ok && (idx == IDX_IRQ_STAT);
	wire hit_imask = addr_ok && (idx == IDX_IRQ_MASK);
	wire hit_any = hit_boost | hit_fw | hit_load | hit_flag | hit_fault | hit_pd | hit_mode |
		hit_run | hit_hold | hit_idle | hit_istat | hit_imask;

	// Read data is captured one cycle ahead so that prdata comes from a flop
	wire latch_rd = psel && !rd_valid_q && clk_en;
	wire xfer = psel && penable && rd_valid_q && clk_en;
	wire wr = xfer && pwrite && hit_any;
	wire rd = xfer && !pwrite && hit_any;
	wire mode_ok = (pwdata[31:3] == 29'h0) && (pwdata[2:0] <= MODE_RUN_EN);

	wire [31:0] rd_mux =
		hit_boost ? {24'h0, boost_q} :
		hit_fw ? {16'h0, fw_delay_q} :
		hit_load ? {22'h0, load_q} :
		hit_flag ? {31'h0, stall_flag_q} :
		hit_fault ? {24'h0, fault_q} :
		hit_pd ? {16'h0, pd_delay_q} :
		hit_mode ? {29'h0, mode_q} :
		hit_run ? {24'h0, run_q} :
		hit_hold ? {24'h0, hold_q} :
		hit_idle ? {16'h0, step_idle_q} :
		hit_istat ? {28'h0, irq_stat_q} :
		hit_imask ? {28'h0, irq_mask_q} : 32'h0;

	assign prdata = prdata_q;
	assign pready = psel && penable && rd_valid_q && clk_en;
	assign pslverr = pready && !hit_any;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata_q <= 32'h0;
			rd_valid_q <= 1'b0;
		end else if (clk_en) begin
			if (latch_rd) begin
				prdata_q <= rd_mux;
				rd_valid_q <= 1'b1;
			end else if (xfer || !psel) begin
				rd_valid_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			boost_q <= RST_BOOST;
			fw_delay_q <= RST_FREEWHEEL;
			pd_delay_q <= RST_PD_DELAY;
			run_q <= RST_RUN;
			hold_q <= RST_HOLD;
			step_idle_q <= RST_STEP_IDLE;
			irq_mask_q <= RST_IRQ_MASK;
			mode_q <= MODE_CMD;
		end else if (clk_en && wr) begin
			if (hit_boost)
				boost_q <= pwdata[7:0];
			if (hit_fw)
				fw_delay_q <= pwdata[15:0];
			// Zero would mean instant standby, outside the legal range
			if (hit_pd && pwdata[15:0] != 16'h0)
				pd_delay_q <= pwdata[15:0];
			if (hit_run)
				run_q <= pwdata[7:0];
			if (hit_hold)
				hold_q <= pwdata[7:0];
			if (hit_idle)
				step_idle_q <= pwdata[15:0];
			if (hit_imask)
				irq_mask_q <= pwdata[IRQ_W-1:0];
			if (hit_mode && mode_ok)
				mode_q <= scsc_mode_t'(pwdata[2:0]);
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers and step edge
	// ----------------------------------------------------------------
	logic step_m_q, step_s_q, step_d_q, ena_m_q, ena_s_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			step_m_q <= 1'b0;
			step_s_q <= 1'b0;
			step_d_q <= 1'b0;
			ena_m_q <= 1'b0;
			ena_s_q <= 1'b0;
		end else if (clk_en) begin
			step_m_q <= step_pin;
			step_s_q <= step_m_q;
			step_d_q <= step_s_q;
			ena_m_q <= enable_pin;
			ena_s_q <= ena_m_q;
		end
	end
	wire step_edge = step_s_q && !step_d_q;

	// ----------------------------------------------------------------
	// 10 ms tick
	// ----------------------------------------------------------------
	logic [31:0] tick_cnt_q;
	wire tick = (tick_cnt_q == 32'(TICK_LEN - 1));
	always_ff @(posedge clk_sys) begin
		if (rst)
			tick_cnt_q <= 32'h0;
		else if (clk_en)
			tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
	end

	// ----------------------------------------------------------------
	// Standstill and step idle timers
	// ----------------------------------------------------------------
	logic [15:0] still_cnt_q, idle_cnt_q;
	logic step_seen_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			still_cnt_q <= 16'h0;
			idle_cnt_q <= 16'h0;
			step_seen_q <= 1'b0;
		end else if (clk_en) begin
			// Counter saturates, so long pauses never wrap back to run
			if (!motion.velocity_zero)
				still_cnt_q <= 16'h0;
			else if (tick && still_cnt_q != 16'hffff)
				still_cnt_q <= still_cnt_q + 16'h1;
			if (step_edge) begin
				idle_cnt_q <= 16'h0;
				step_seen_q <= 1'b1;
			end else if (tick && idle_cnt_q != 16'hffff) begin
				idle_cnt_q <= idle_cnt_q + 16'h1;
			end
		end
	end

	wire standby = motion.velocity_zero && (still_cnt_q >= pd_delay_q);
	wire freewheel = motion.velocity_zero && (fw_delay_q != 16'h0) &&
		(still_cnt_q >= fw_delay_q);
	wire step_active = step_seen_q && (idle_cnt_q < step_idle_q);

	// ----------------------------------------------------------------
	// Current and stage selection
	// ----------------------------------------------------------------
	wire [7:0] ramp_cur = (boost_q == 8'h0) ? run_q : boost_q;
	wire [7:0] cmd_cur = standby ? hold_q : (motion.ramping ? ramp_cur : run_q);
	logic [7:0] cur_d;
	logic stage_d, power_d;
	always_comb begin
		cur_d = cmd_cur;
		stage_d = 1'b1;
		power_d = !freewheel;
		case (mode_q)
			MODE_CMD: begin
				cur_d = cmd_cur;
			end
			MODE_ENA: begin
				cur_d = ena_s_q ? run_q : hold_q;
			end
			MODE_AUTO: begin
				cur_d = step_active ? run_q : hold_q;
			end
			MODE_RUN: begin
				cur_d = run_q;
			end
			MODE_AUTO_EN: begin
				cur_d = step_active ? run_q : hold_q;
				stage_d = ena_s_q;
			end
			MODE_RUN_EN: begin
				cur_d = run_q;
				stage_d = ena_s_q;
			end
			default: begin
				cur_d = cmd_cur;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			drv <= '{power_en: 1'b1, stage_en: 1'b1, current: RST_HOLD};
		else if (clk_en)
			drv <= '{power_en: power_d, stage_en: stage_d, current: cur_d};
	end

	// ----------------------------------------------------------------
	// Stall stop, load value and status flags
	// ----------------------------------------------------------------
	wire stall_evt = motion.stall_detect && !motion.velocity_zero;
	wire flag_rd = rd && hit_flag;
	wire stat_rd = rd && hit_istat;
	logic standby_d1_q, fw_d1_q;
	wire [IRQ_W-1:0] irq_evt = {|driver_faults, freewheel && !fw_d1_q, standby && !standby_d1_q, stall_evt};

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stall_stop <= 1'b0;
			stall_flag_q <= 1'b0;
			load_q <= 10'h0;
			fault_q <= 8'h0;
			irq_stat_q <= '0;
			standby_d1_q <= 1'b0;
			fw_d1_q <= 1'b0;
			irq <= 1'b0;
		end else if (clk_en) begin
			stall_stop <= stall_evt;
			// A stall in the clearing cycle keeps the flag set
			if (stall_evt)
				stall_flag_q <= 1'b1;
			else if (flag_rd || motion.motion_start)
				stall_flag_q <= 1'b0;
			load_q <= load_value;
			fault_q <= driver_faults;
			irq_stat_q <= (stat_rd ? '0 : irq_stat_q) | irq_evt;
			standby_d1_q <= standby;
			fw_d1_q <= freewheel;
			irq <= |(((stat_rd ? '0 : irq_stat_q) | irq_evt) & irq_mask_q);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_stall_seen;
		clk_en && stall_evt;
	endsequence
	sequence s_flag_clear_req;
		clk_en && !stall_evt && (flag_rd || motion.motion_start);
	endsequence

	a_boost_select: assert property (clk_en && mode_q == MODE_CMD && motion.ramping && !standby
		|=> drv.current == $past(ramp_cur))
		else $error("ramp current not boost or run");
	a_freewheel_cut: assert property (clk_en && mode_q == MODE_CMD && fw_delay_q == 16'h0
		|=> drv.power_en)
		else $error("power cut with freewheel disabled");
	a_load_track: assert property (clk_en |=> load_q == $past(load_value))
		else $error("load value not tracked");
	a_stall_set: assert property (s_stall_seen |=> stall_flag_q && stall_stop)
		else $error("stall did not set flag");
	a_stall_clear: assert property (s_flag_clear_req |=> !stall_flag_q)
		else $error("stall flag not cleared");
	a_standby_cur: assert property (clk_en && mode_q == MODE_CMD && standby
		|=> drv.current == $past(hold_q))
		else $error("standby current not applied");
	a_mode_hold: assert property (clk_en && mode_q == MODE_ENA
		|=> drv.current == ($past(ena_s_q) ? $past(run_q) : $past(hold_q)))
		else $error("enable pin current select wrong");
	a_run_fixed: assert property (clk_en && (mode_q == MODE_RUN || mode_q == MODE_RUN_EN)
		|=> drv.current == $past(run_q))
		else $error("run current not permanent");
	a_stage_gate: assert property (clk_en && (mode_q == MODE_AUTO_EN || mode_q == MODE_RUN_EN)
		|=> drv.stage_en == $past(ena_s_q))
		else $error("stages not gated by enable");
	a_mode_reject: assert property (wr && hit_mode && !mode_ok |=> $stable(mode_q))
		else $error("illegal mode accepted");
	a_mode_take: assert property (wr && hit_mode && mode_ok |=> mode_q == $past(pwdata[2:0]))
		else $error("legal mode not taken");
	a_freewheel_off: assert property (clk_en && motion.velocity_zero && fw_delay_q != 16'h0
		&& still_cnt_q >= fw_delay_q |=> !drv.power_en)
		else $error("power kept after freewheel delay");
	a_flag_sticky: assert property (clk_en && stall_flag_q && !flag_rd && !motion.motion_start
		|=> stall_flag_q)
		else $error("stall flag dropped without clear");
	a_pd_reject: assert property (wr && hit_pd && pwdata[15:0] == 16'h0 |=> $stable(pd_delay_q))
		else $error("zero power-down delay accepted");
	a_run_plain: assert property (clk_en && mode_q == MODE_CMD && !standby && !motion.ramping
		|=> drv.current == $past(run_q))
		else $error("run current not used while moving");
	a_cmd_pins: assert property (clk_en && mode_q == MODE_CMD
		|=> drv.current == $past(cmd_cur) && drv.stage_en)
		else $error("pins affected command mode");

	// Run current must follow a step two cycles later: edge, then armed idle window
	sequence s_step_taken;
		clk_en && step_edge;
	endsequence
	sequence s_auto_armed;
		clk_en && (mode_q == MODE_AUTO || mode_q == MODE_AUTO_EN) && step_idle_q != 16'h0;
	endsequence

	a_step_wakes: assert property (s_step_taken ##1 s_auto_armed |=> drv.current == $past(run_q))
		else $error("step pulse did not apply run current");
	a_auto_hold: assert property (clk_en && (mode_q == MODE_AUTO || mode_q == MODE_AUTO_EN)
		&& !step_active |=> drv.current == $past(hold_q))
		else $error("hold current not applied after idle");
	a_stage_on: assert property (clk_en && (mode_q == MODE_CMD || mode_q == MODE_ENA ||
		mode_q == MODE_AUTO || mode_q == MODE_RUN) |=> drv.stage_en)
		else $error("stages gated in a mode without gating");
	a_run_en: assert property (clk_en && mode_q == MODE_RUN_EN
		|=> drv.current == $past(run_q) && drv.stage_en == $past(ena_s_q))
		else $error("run with enable gating wrong");

endmodule // scsc_top

//--- tb/scsc_far.sv
// Far-side model: motor driver stage and external step and enable pin source
`timescale 1ns/100ps
module scsc_far import scsc_pkg::*; (
	input wire logic clk_sys,
	input wire logic stall_stop,
	output scsc_motion_t motion,
	output logic [9:0] load_value,
	output logic [7:0] driver_faults,
	output logic step_pin,
	output logic enable_pin
);
	initial begin
		motion = '0;
		load_value = '0;
		driver_faults = '0;
		step_pin = 1'b0;
		enable_pin = 1'b0;
	end

	// The driver drops its stall report once the stop request arrives
	always @(posedge clk_sys) begin
		if (stall_stop)
			motion.stall_detect <= 1'b0;
	end

	// Motion state changes right after a clock edge, like the motion controller would
	task automatic drive(input logic vz, input logic rp);
		@(posedge clk_sys);
		motion.velocity_zero <= vz;
		motion.ramping <= rp;
	endtask
	task automatic enable(input logic e);
		@(posedge clk_sys);
		enable_pin <= e;
	endtask
	task automatic stall();
		@(posedge clk_sys);
		motion.stall_detect <= 1'b1;
	endtask
	task automatic start();
		@(posedge clk_sys);
		motion.motion_start <= 1'b1;
		@(posedge clk_sys);
		motion.motion_start <= 1'b0;
	endtask
	task automatic meas(input logic [9:0] l, input logic [7:0] f);
		@(posedge clk_sys);
		load_value <= l;
		driver_faults <= f;
	endtask

	// Step pulse held three cycles so the synchroniser cannot miss it
	task automatic step();
		@(posedge clk_sys);
		step_pin <= 1'b1;
		repeat (3) @(posedge clk_sys);
		step_pin <= 1'b0;
	endtask
endmodule // scsc_far

//--- tb/stepper_current_standby_control_bench.sv
// Self-checking bench for the stepper current and standby control block
`timescale 1ns/100ps
module stepper_current_standby_control_bench import scsc_pkg::*; ;
	logic clk_sys, rst, clk_en, psel, penable, pwrite, pready, pslverr, stall_stop, irq, re;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [9:0] load_value;
	logic [7:0] driver_faults;
	logic step_pin, enable_pin;
	scsc_motion_t motion;
	scsc_drv_t drv;
	int bad_count = 0;
	int checks = 0;
	int stops = 0;

	// Flops change by non-blocking update, so this sees the value sampled at the edge
	always @(posedge clk_sys) begin
		if (stall_stop === 1'b1)
			stops++;
	end

	scsc_top #(.TICK_LEN(10)) DUT (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .motion(motion), .load_value(load_value),
		.driver_faults(driver_faults), .step_pin(step_pin), .enable_pin(enable_pin), .drv(drv),
		.stall_stop(stall_stop), .irq(irq));
	scsc_far FAR (.clk_sys(clk_sys), .stall_stop(stall_stop), .motion(motion), .load_value(load_value),
		.driver_faults(driver_faults), .step_pin(step_pin), .enable_pin(enable_pin));

	// ----
	// Helpers
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, i, 2'h0};
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Values read right after the edge are those sampled at it; only the watchdog ends a hang
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] i, input logic [31:0] e);
		apb(1'b0, i, 32'h0);
		chk(rv, e);
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		apb(1'b1, i, d);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic mv(input logic vz, input logic rp);
		FAR.drive(vz, rp);
	endtask
	task automatic en(input logic e);
		FAR.enable(e);
	endtask
	task automatic dchk(input logic [31:0] e);
		chk(32'(drv), e);
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		rd(IDX_FREEWHEEL, 32'h0);
		rd(IDX_PD_DELAY, 32'hc8);
		rd(IDX_MODE, 32'h0);
		rd(IDX_BOOST, 32'h0);
		rd(IDX_RUN, 32'h80);
		rd(IDX_HOLD, 32'h20);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, re}, 32'h1);
		chk(rv, 32'h0);
	endtask
	task automatic t_boost();
		mv(1'b0, 1'b1);
		wr(IDX_BOOST, 32'h40);
		cyc(3);
		dchk(32'h340);
		wr(IDX_BOOST, 32'h0);
		cyc(3);
		dchk(32'h380);
		mv(1'b0, 1'b0);
	endtask
	task automatic t_stall();
		FAR.meas(10'h3ff, 8'h5a);
		rd(IDX_LOAD, 32'h3ff);
		rd(IDX_FAULT, 32'h5a);
		FAR.meas(10'h3ff, 8'h00);
		rd(IDX_IRQ_STAT, 32'h8);
		wr(IDX_IRQ_MASK, 32'h1);
		FAR.stall();
		cyc(4);
		chk(stops, 32'd2);
		chk({31'h0, irq}, 32'h1);
		rd(IDX_STALL_FLAG, 32'h1);
		rd(IDX_STALL_FLAG, 32'h0);
		rd(IDX_IRQ_STAT, 32'h1);
		cyc(2);
		chk({31'h0, irq}, 32'h0);
		FAR.stall();
		cyc(4);
		FAR.start();
		rd(IDX_STALL_FLAG, 32'h0);
	endtask
	task automatic t_standstill();
		wr(IDX_FREEWHEEL, 32'h5);
		wr(IDX_PD_DELAY, 32'h2);
		wr(IDX_PD_DELAY, 32'h0);
		rd(IDX_PD_DELAY, 32'h2);
		mv(1'b1, 1'b0);
		cyc(5);
		dchk(32'h380);
		cyc(25);
		dchk(32'h320);
		cyc(40);
		dchk(32'h120);
		rd(IDX_IRQ_STAT, 32'h7);
		mv(1'b0, 1'b0);
		wr(IDX_FREEWHEEL, 32'h0);
		mv(1'b1, 1'b0);
		cyc(100);
		dchk(32'h320);
		mv(1'b0, 1'b0);
		cyc(3);
	endtask
	task automatic t_modes();
		wr(IDX_MODE, 32'h1);
		wr(IDX_MODE, 32'h7);
		rd(IDX_MODE, 32'h1);
		en(1'b0);
		cyc(6);
		dchk(32'h320);
		en(1'b1);
		cyc(6);
		dchk(32'h380);
		wr(IDX_MODE, 32'h0);
		en(1'b0);
		FAR.step();
		cyc(6);
		dchk(32'h380);
		wr(IDX_MODE, 32'h3);
		cyc(6);
		dchk(32'h380);
		wr(IDX_MODE, 32'h5);
		cyc(3);
		dchk(32'h280);
		wr(IDX_STEP_IDLE, 32'h2);
		wr(IDX_MODE, 32'h2);
		FAR.step();
		cyc(3);
		dchk(32'h380);
		cyc(40);
		dchk(32'h320);
		wr(IDX_MODE, 32'h4);
		FAR.step();
		cyc(3);
		dchk(32'h280);
		cyc(40);
		dchk(32'h220);
		en(1'b1);
		cyc(6);
		dchk(32'h320);
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// Whole sequence needs about 450 cycles; allow far more
	initial begin
		#2000000;
		bad_count++;
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (16) @(posedge clk_sys);
		dchk(32'h320);
		rst <= 1'b0;
		t_reset();
		t_boost();
		t_stall();
		t_standstill();
		t_modes();
		print_verdict();
	end
endmodule // stepper_current_standby_control_bench
